/* hdl/sdram_link_pkg.sv */
// Shared constants for the SDRAM link.
// Assumes one 20 MHz clock shared by both ends of the link.
`default_nettype none
package sdram_link_pkg;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int BANK_W = 2;
    localparam int NBANKS = 4;
    localparam int DATA_W = 16;
    // Command code is {row strobe, column strobe, write enable}, all active low.
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Mode word fields.
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_WB_BIT = 9;
    localparam int PRE_ALL_BIT = 10;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [11:0] MODE_RESET = 12'h000;
    // Controller registers, Avalon word addresses.
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_WDATA = 3'h2;
    localparam logic [2:0] REG_RDATA = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    // Command register fields.
    localparam int OP_LSB = 0;
    localparam int BANK_LSB = 3;
    localparam int ROW_LSB = 5;
    localparam int COL_LSB = 17;
    localparam int APRE_BIT = 26;
    localparam logic [2:0] OP_MODE = 3'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_PRE_ALL = 3'h3;
    localparam logic [2:0] OP_REFRESH = 3'h4;
    // Refresh spacing: 4096 refreshes in 64 ms, rounded down to cycles.
    localparam int CLK_HZ = 20000000;
    localparam int REFRESH_WINDOW_MS = 64;
    localparam int REFRESH_ROWS = 4096;
    localparam int REFRESH_GAP_CYC = (REFRESH_WINDOW_MS * (CLK_HZ / 1000)) / REFRESH_ROWS;
    localparam int FIFO_DEPTH = 16;
    localparam int FULL_PAGE_CTL_WORDS = 8;

    // Number of words in a burst for a length code.
    function automatic logic [9:0] burst_words(input logic [2:0] bl);
        unique case (bl)
            3'h0: burst_words = 10'h001;
            3'h1: burst_words = 10'h002;
            3'h2: burst_words = 10'h004;
            3'h3: burst_words = 10'h008;
            default: burst_words = 10'h200;
        endcase
    endfunction : burst_words

    // Column of word idx within a burst, sequential or interleaved order.
    function automatic logic [8:0] burst_col(input logic [8:0] start, input logic [9:0] idx,
                                             input logic [2:0] bl, input logic ilv);
        logic [9:0] m;
        logic [8:0] off;
        m = burst_words(bl) - 10'h001;
        off = ilv ? (start ^ idx[8:0]) : 9'(start + idx[8:0]);
        burst_col = (start & ~m[8:0]) | (off & m[8:0]);
    endfunction : burst_col
endpackage : sdram_link_pkg
`default_nettype wire

/* hdl/sdram_link_if.sv */
// Link between the SDRAM controller end and the SDRAM device end.
// Data lines are resolved per byte from the two ends' enables.
`default_nettype none
interface sdram_link_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [1:0] dqm;
    logic [15:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [15:0] dev_dq_o;
    logic [1:0] dev_dq_oe;
    logic [15:0] dq_bus;

    assign dq_bus[7:0] = ctl_dq_oe ? ctl_dq_o[7:0] : (dev_dq_oe[0] ? dev_dq_o[7:0] : 8'h00);
    assign dq_bus[15:8] = ctl_dq_oe ? ctl_dq_o[15:8] : (dev_dq_oe[1] ? dev_dq_o[15:8] : 8'h00);

    modport ctl (output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe, input dq_bus);
    modport dev (input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_bus, output dev_dq_o, dev_dq_oe);
endinterface : sdram_link_if
`default_nettype wire

/* hdl/sdram_dev_end.sv */
// SDRAM device end: four banks of 16-bit words, bursts, mode word, masks.
// Assumes the controller end shares clk_sys.
// Functional notes
// [RQ1] Open row bursts 1, 2, 4, 8 or page.
// [RQ2] Internal counter steps burst columns.
// [RQ3] New column read accepted every cycle.
// [RQ4] Four independent banks of 16-bit words.
// [RQ5] Mode word sets length, latency, order.
// [RQ6] Read latency two or three cycles.
// [RQ7] Option: burst reads, single-word writes.
// [RQ8] Separate lower and upper byte masks.
// [RQ9] Row closes by auto or explicit precharge.
// [RQ10] Controller refreshes 4096 rows per 64 ms.
// [RQ11] Twelve-bit row, nine-bit column, two bank bits.
// [RQ12] Precharge-all bit selects all or one bank.
// [RQ13] Deselected decoder ignores commands, burst continues.
// [RQ14] Read mask floats two later, write mask immediate.
// [RQ15] Controller programs mode before first access.
// [RQ16] All inputs sampled on rising clock edge.
`default_nettype none
module sdram_dev_end #(
    parameter int ROW_KEEP_W = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    sdram_link_if.dev link,
    output logic mode_set,
    output logic [sdram_link_pkg::NBANKS-1:0] bank_open
);
    import sdram_link_pkg::*;

    localparam int MEM_AW = BANK_W + ROW_KEEP_W + COL_W;

    logic [11:0] mode_q, mode_d;
    logic mode_ok_q, mode_ok_d;
    logic [NBANKS-1:0] open_q, open_d;
    logic [ROW_W-1:0] row_q [NBANKS];
    logic [ROW_W-1:0] row_d [NBANKS];
    logic bon_q, bon_d;
    logic bwr_q, bwr_d;
    logic bap_q, bap_d;
    logic [BANK_W-1:0] bbank_q, bbank_d;
    logic [COL_W-1:0] bstart_q, bstart_d;
    logic [9:0] bidx_q, bidx_d;
    logic p0v_q, p0v_d, p1v_q, p1v_d;
    logic [DATA_W-1:0] p0_q, p0_d, p1_q, p1_d;
    logic [DATA_W-1:0] dq_q, dq_d;
    logic [1:0] oe_q, oe_d;
    logic [1:0] dqm_q;
    logic [DATA_W-1:0] mem_q [2**MEM_AW];
    logic mem_we;
    logic [1:0] mem_be;
    logic [MEM_AW-1:0] mem_idx;
    logic [2:0] cmd;
    logic start, go, last, cw, cap;
    logic [BANK_W-1:0] cb;
    logic [COL_W-1:0] cs, col;
    logic [9:0] ci, clen;
    logic [2:0] bl;

    always_comb begin
        mode_d = mode_q;
        mode_ok_d = mode_ok_q;
        open_d = open_q;
        row_d = row_q;
        bon_d = 1'b0;
        bwr_d = bwr_q;
        bap_d = bap_q;
        bbank_d = bbank_q;
        bstart_d = bstart_q;
        bidx_d = bidx_q;
        p0v_d = 1'b0;
        p0_d = p0_q;
        mem_we = 1'b0;
        mem_be = 2'b00;
        mem_idx = '0;
        col = '0;
        last = 1'b0;
        bl = mode_q[MODE_BL_LSB +: 3];
        // [RQ13] Deselect masks commands.
        cmd = link.cs_n ? CMD_NOP : {link.ras_n, link.cas_n, link.we_n};
        // [RQ3] Column command restarts.
        start = (cmd == CMD_RD || cmd == CMD_WR) && open_q[link.ba];
        // [RQ13] Burst keeps running.
        go = start || (bon_q && cmd != CMD_BST && cmd != CMD_PRE);
        if (start) begin
            cb = link.ba;
            cs = link.addr[COL_W-1:0];
            ci = 10'h000;
            cw = (cmd == CMD_WR);
            cap = link.addr[PRE_ALL_BIT];
        end else begin
            cb = bbank_q;
            cs = bstart_q;
            ci = bidx_q;
            cw = bwr_q;
            cap = bap_q;
        end
        // [RQ7] Single-word write option.
        clen = (cw && mode_q[MODE_WB_BIT]) ? 10'h001 : burst_words(bl);
        if (go) begin
            // [RQ2] Internal column counter.
            col = burst_col(cs, ci, bl, mode_q[MODE_BT_BIT]);
            // [RQ4] Bank-indexed storage.
            mem_idx = {cb, row_q[cb][ROW_KEEP_W-1:0], col};
            if (cw) begin
                mem_we = 1'b1;
                // [RQ14] Write mask immediate.
                mem_be = ~link.dqm;
            end else begin
                p0v_d = 1'b1;
                p0_d = mem_q[mem_idx];
            end
            // [RQ1] Burst end by length.
            last = (cw && mode_q[MODE_WB_BIT]) || (bl != BL_FULL && ci == clen - 10'h001);
            bon_d = !last;
            bidx_d = ci + 10'h001;
            bbank_d = cb;
            bstart_d = cs;
            bwr_d = cw;
            bap_d = cap;
            // [RQ9] Auto precharge close.
            if (last && cap) begin
                open_d[cb] = 1'b0;
            end
        end
        unique case (cmd)
            CMD_ACT: begin
                // [RQ11] Row address latch.
                open_d[link.ba] = 1'b1;
                row_d[link.ba] = link.addr;
            end
            CMD_PRE: begin
                // [RQ12] All or one bank.
                if (link.addr[PRE_ALL_BIT]) begin
                    open_d = '0;
                end else begin
                    open_d[link.ba] = 1'b0;
                end
            end
            CMD_MRS: begin
                // [RQ5] Mode word load.
                mode_d = link.addr;
                mode_ok_d = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        p1v_d = p0v_q;
        p1_d = p0_q;
        // [RQ6] Latency two or three.
        if (mode_q[MODE_CL_LSB +: 3] == CL_2) begin
            dq_d = p0_q;
            oe_d = {2{p0v_q}} & ~dqm_q;
        end else begin
            dq_d = p1_q;
            // [RQ14] Read mask latency two.
            oe_d = {2{p1v_q}} & ~dqm_q;
        end
    end

    // [RQ16] Rising edge sampling.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
            mode_ok_q <= 1'b0;
            open_q <= '0;
            row_q <= '{default: '0};
            bon_q <= 1'b0;
            bwr_q <= 1'b0;
            bap_q <= 1'b0;
            bbank_q <= '0;
            bstart_q <= '0;
            bidx_q <= '0;
            p0v_q <= 1'b0;
            p0_q <= '0;
            p1v_q <= 1'b0;
            p1_q <= '0;
            dq_q <= '0;
            oe_q <= '0;
            dqm_q <= '0;
        end else begin
            mode_q <= mode_d;
            mode_ok_q <= mode_ok_d;
            open_q <= open_d;
            row_q <= row_d;
            bon_q <= bon_d;
            bwr_q <= bwr_d;
            bap_q <= bap_d;
            bbank_q <= bbank_d;
            bstart_q <= bstart_d;
            bidx_q <= bidx_d;
            p0v_q <= p0v_d;
            p0_q <= p0_d;
            p1v_q <= p1v_d;
            p1_q <= p1_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            dqm_q <= link.dqm;
        end
    end

    // [RQ8] Per-byte lane write.
    always_ff @(posedge clk_sys) begin
        if (mem_we && mem_be[0]) begin
            mem_q[mem_idx][7:0] <= link.dq_bus[7:0];
        end
        if (mem_we && mem_be[1]) begin
            mem_q[mem_idx][15:8] <= link.dq_bus[15:8];
        end
    end

    assign link.dev_dq_o = dq_q;
    assign link.dev_dq_oe = oe_q;
    assign mode_set = mode_ok_q;
    assign bank_open = open_q;
endmodule : sdram_dev_end
`default_nettype wire

/* hdl/sdram_ctl_end.sv */
// SDRAM controller end: Avalon-MM register slave, command sequencer,
// refresh timer and a read-data FIFO.
// Assumes the device end shares clk_sys.
`default_nettype none
module data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        out_data = mem_q[rp_q];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
        level = cnt_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : data_fifo

module sdram_ctl_end #(
    parameter int REFRESH_GAP = sdram_link_pkg::REFRESH_GAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    sdram_link_if.ctl link
);
    import sdram_link_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_GAP = 4'b0010,
        ST_RW = 4'b0100,
        ST_DRAIN = 4'b1000
    } state_t;

    state_t st_q, st_d;
    logic [31:0] cmdr_q, cmdr_d, rdata_q, rdata_d;
    logic pend_q, pend_d, wait_q, wait_d, ref_q, ref_d, isrd_q, isrd_d;
    logic [11:0] mode_q, mode_d;
    logic [17:0] wdat_q, wdat_d;
    logic [9:0] cnt_q, cnt_d, rcnt_q, rcnt_d;
    logic csn_q, csn_d, dqoe_q, dqoe_d;
    logic [2:0] cmd_q, cmd_d;
    logic [1:0] ba_q, ba_d, dqm_q, dqm_d;
    logic [11:0] addr_q, addr_d;
    logic [15:0] dqo_q, dqo_d, f_data;
    logic [9:0] n, wn, cl;
    logic f_in, f_rdy, f_ov, f_pop, done, take;
    logic [$clog2(FIFO_DEPTH):0] f_lvl;

    data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rd_fifo (
        .clk_sys, .rst_n, .in_valid(f_in), .in_ready(f_rdy), .in_data(link.dq_bus),
        .out_valid(f_ov), .out_ready(f_pop), .out_data(f_data), .level(f_lvl)
    );

    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        cmdr_d = cmdr_q;
        mode_d = mode_q;
        wdat_d = wdat_q;
        pend_d = pend_q && !take;
        done = (read || write) && !wait_q;
        f_pop = done && read && address == REG_RDATA && rdata_q[16];
        if (wait_q && (read || write) && !(write && address == REG_CMD && pend_q)) begin
            wait_d = 1'b0;
            unique case (address)
                REG_MODE: rdata_d = {20'h0, mode_q};
                REG_WDATA: rdata_d = {14'h0, wdat_q};
                REG_RDATA: rdata_d = {15'h0, f_ov, f_data};
                REG_STATUS: rdata_d = {22'h0, f_lvl, 2'b00, ref_q, pend_q, st_q != ST_IDLE};
                default: rdata_d = (address == REG_CMD) ? cmdr_q : 32'h00000000;
            endcase
        end
        if (done && write) begin
            if (address == REG_CMD) begin
                cmdr_d = writedata;
                pend_d = 1'b1;
            end
            if (address == REG_MODE) begin
                mode_d = writedata[11:0];
            end
            if (address == REG_WDATA) begin
                wdat_d = writedata[17:0];
            end
        end
    end

    always_comb begin
        st_d = st_q;
        take = 1'b0;
        isrd_d = isrd_q;
        cnt_d = 10'(cnt_q + 10'h001);
        csn_d = 1'b1;
        cmd_d = CMD_NOP;
        ba_d = ba_q;
        addr_d = addr_q;
        dqm_d = 2'b00;
        dqoe_d = 1'b0;
        dqo_d = dqo_q;
        ref_d = ref_q;
        rcnt_d = 10'(rcnt_q + 10'h001);
        n = (mode_q[2:0] == BL_FULL) ? 10'(FULL_PAGE_CTL_WORDS) : burst_words(mode_q[2:0]);
        wn = mode_q[MODE_WB_BIT] ? 10'h001 : n;
        cl = {7'h00, mode_q[MODE_CL_LSB +: 3]};
        f_in = (st_q == ST_DRAIN) && isrd_q && cnt_q >= cl && cnt_q < 10'(cl + n);
        unique case (st_q)
            ST_IDLE: begin
                if (ref_q) begin
                    csn_d = 1'b0;
                    cmd_d = CMD_PRE;
                    addr_d = 12'h400;
                    st_d = ST_GAP;
                    isrd_d = 1'b0;
                end else if (pend_q) begin
                    take = 1'b1;
                    if (cmdr_q[2:0] == OP_MODE) begin
                        csn_d = 1'b0;
                        cmd_d = CMD_MRS;
                        addr_d = mode_q;
                    end else if (cmdr_q[2:0] == OP_PRE_ALL) begin
                        csn_d = 1'b0;
                        cmd_d = CMD_PRE;
                        addr_d = 12'h400;
                    end else if (cmdr_q[2:0] == OP_REFRESH) begin
                        ref_d = 1'b1;
                    end else if (cmdr_q[2:0] == OP_WRITE
                            || (cmdr_q[2:0] == OP_READ && f_rdy && 10'(f_lvl) + n <= 10'(FIFO_DEPTH))) begin
                        csn_d = 1'b0;
                        cmd_d = CMD_ACT;
                        ba_d = cmdr_q[BANK_LSB +: 2];
                        addr_d = cmdr_q[ROW_LSB +: 12];
                        isrd_d = (cmdr_q[2:0] == OP_READ);
                        st_d = ST_GAP;
                    end else if (cmdr_q[2:0] == OP_READ) begin
                        take = 1'b0;
                    end
                end
            end
            ST_GAP: begin
                st_d = ST_RW;
                // Both masks high mark a refresh pass.
                dqm_d = {2{cmd_q == CMD_PRE}};
            end
            ST_RW: begin
                csn_d = 1'b0;
                cnt_d = 10'h000;
                st_d = ST_DRAIN;
                if (dqm_q != 2'b11) begin
                    cmd_d = isrd_q ? CMD_RD : CMD_WR;
                    addr_d = {1'b0, cmdr_q[APRE_BIT], 1'b0, cmdr_q[COL_LSB +: 9]};
                    dqoe_d = !isrd_q;
                    dqo_d = wdat_q[15:0];
                    dqm_d = isrd_q ? 2'b00 : wdat_q[17:16];
                end else begin
                    cmd_d = CMD_REF;
                    ref_d = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                dqm_d = isrd_q ? 2'b00 : 2'b11;
                if (mode_q[2:0] == BL_FULL && cnt_q == 10'(FULL_PAGE_CTL_WORDS - 1)) begin
                    csn_d = 1'b0;
                    cmd_d = CMD_BST;
                end
                if (isrd_q ? (cnt_q == 10'(cl + n - 10'h001)) : (cnt_q >= 10'(wn - 10'h001))) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
        // [RQ10] Refresh timer.
        if (rcnt_q == 10'(REFRESH_GAP - 1)) begin
            rcnt_d = 10'h000;
            ref_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cmdr_q <= '0;
            rdata_q <= '0;
            pend_q <= 1'b0;
            wait_q <= 1'b1;
            ref_q <= 1'b0;
            isrd_q <= 1'b0;
            mode_q <= MODE_RESET;
            wdat_q <= '0;
            cnt_q <= '0;
            rcnt_q <= '0;
            csn_q <= 1'b1;
            cmd_q <= CMD_NOP;
            ba_q <= '0;
            addr_q <= '0;
            dqm_q <= '0;
            dqo_q <= '0;
            dqoe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cmdr_q <= cmdr_d;
            rdata_q <= rdata_d;
            pend_q <= pend_d;
            wait_q <= wait_d;
            ref_q <= ref_d;
            isrd_q <= isrd_d;
            mode_q <= mode_d;
            wdat_q <= wdat_d;
            cnt_q <= cnt_d;
            rcnt_q <= rcnt_d;
            csn_q <= csn_d;
            cmd_q <= cmd_d;
            ba_q <= ba_d;
            addr_q <= addr_d;
            dqm_q <= dqm_d;
            dqo_q <= dqo_d;
            dqoe_q <= dqoe_d;
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign link.cs_n = csn_q;
    assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
    assign link.ba = ba_q;
    assign link.addr = addr_q;
    assign link.dqm = dqm_q;
    assign link.ctl_dq_o = dqo_q;
    assign link.ctl_dq_oe = dqoe_q;
endmodule : sdram_ctl_end
`default_nettype wire

/* verification/sdram_link_assertions.sv */
// Checker for the link: command order, read timing, byte masks, refresh spacing.
// Assumes the bench instantiates it beside the link interface, clocked by clk_sys.
`default_nettype none
module sdram_link_assertions
    import sdram_link_pkg::*;
#(
    parameter int REFRESH_GAP = 312
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    input wire logic ctl_dq_oe,
    input wire logic [1:0] dev_dq_oe
);
    logic [2:0] cmd;
    logic rd, pre, rf;
    logic [15:0] gap_q, gap_d;
    assign cmd = {ras_n, cas_n, we_n};
    assign rd = !cs_n && cmd == CMD_RD;
    assign pre = !cs_n && cmd == CMD_PRE;
    assign rf = !cs_n && cmd == CMD_REF;
    // Cycles since the last refresh command.
    always_comb begin
        gap_d = rf ? 16'h0000 : gap_q + 16'h0001;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    bus_no_fight_a: assert property (!(ctl_dq_oe && dev_dq_oe != 2'h0))
        else $error("Data bus fight");
    act_to_column_a: assert property (!cs_n && cmd == CMD_ACT |-> ##2
        !cs_n && (cmd == CMD_RD || cmd == CMD_WR) && ba == $past(ba, 2)) else $error("No column after activate");
    read_latency_a: assert property (rd && dqm == 2'h0 ##1 dqm == 2'h0 |-> ##[1:2] dev_dq_oe != 2'h0)
        else $error("Read data late");
    read_cause_a: assert property ($rose(dev_dq_oe != 2'h0) |-> $past(rd, 2) || $past(rd, 3))
        else $error("Drive without read");
    lower_mask_a: assert property (dqm[0] |-> ##2 !dev_dq_oe[0])
        else $error("Lower byte not floated");
    upper_mask_a: assert property (dqm[1] |-> ##2 !dev_dq_oe[1])
        else $error("Upper byte not floated");
    precharge_all_a: assert property (pre |-> addr[PRE_ALL_BIT])
        else $error("Precharge without all bit");
    refresh_order_a: assert property (rf |-> $past(pre, 2))
        else $error("Refresh without precharge");
    refresh_gap_a: assert property (gap_q < 16'(REFRESH_GAP + 40))
        else $error("Refresh overdue");
    cover property (rd);
    cover property (!cs_n && cmd == CMD_WR);
    cover property (rf);
    cover property (!cs_n && cmd == CMD_MRS);
endmodule : sdram_link_assertions
`default_nettype wire

/* verification/tb_four_bank_sdram_burst_access.sv */
// Bench: both ends joined, driven over Avalon-MM, reads checked from a queue.
// Assumes hdl files and the checker compile first.
`default_nettype none
module tb_four_bank_sdram_burst_access;
    timeunit 1ns;
    timeprecision 1ns;
    import sdram_link_pkg::*;
    localparam logic [8:0] BASE = 9'h040;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic mode_set;
    logic [3:0] bank_open;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] mem[4][8];
    int num_errors = 0;
    int tests_run = 0;
    int seed = 24270;
    sdram_link_if link();
    sdram_dev_end i_sdram_dev_end (.clk_sys, .rst_n, .link, .mode_set, .bank_open);
    sdram_ctl_end #(.REFRESH_GAP(40)) i_sdram_ctl_end (.clk_sys, .rst_n, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .link);
    sdram_link_assertions #(.REFRESH_GAP(40)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .dqm(link.dqm),
        .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int k;
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk_sys);
            if (!waitrequest) break;
        end
        if (k == 3000) begin
            num_errors++;
            tally_and_finish();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : av
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(a, 1'b1, d, q);
    endtask : wr
    task automatic chk(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        exp_q.push_back(e);
        msk_q.push_back(m);
        av(a, 1'b0, 32'h0, q);
    endtask : chk
    task automatic now(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : now
    // Queues a command and polls until idle.
    task automatic op(input logic [2:0] o, input logic [1:0] b, input logic [8:0] c, input logic ap);
        logic [31:0] q;
        int k;
        wr(REG_CMD, {5'h0, ap, c, 12'h005, b, o});
        for (k = 0; k < 100; k++) begin
            av(REG_STATUS, 1'b0, 32'h0, q);
            if (q[1:0] == 2'h0) break;
        end
        if (k == 100) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : op
    function automatic logic [8:0] col_of(input logic [8:0] s, input int j, input logic [2:0] bl, input logic ilv);
        logic [8:0] m;
        m = (bl == BL_FULL) ? 9'h1FF : 9'((1 << bl) - 1);
        col_of = (s & ~m) | ((ilv ? (s ^ 9'(j)) : 9'(s + 9'(j))) & m);
    endfunction : col_of
    always @(posedge clk_sys) begin
        if (read && !waitrequest && exp_q.size() > 0) begin
            now(readdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    initial begin
        logic [2:0] blv;
        logic ilv;
        logic [1:0] bk;
        logic [8:0] s;
        logic [15:0] d;
        int n;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(REG_MODE, 32'h0, 32'hFFF);
        wr(3'h6, 32'hFFFFFFFF);
        chk(3'h6, 32'h0, 32'hFFFFFFFF);
        now(mode_set, 32'h0);
        wr(REG_MODE, 32'h20);
        op(OP_MODE, 2'h0, 9'h000, 1'b0);
        now(mode_set, 32'h1);
        for (int b = 0; b < 4; b++) begin
            for (int c = 0; c < 8; c++) begin
                mem[b][c] = 16'($random(seed));
                wr(REG_WDATA, {16'h0, mem[b][c]});
                op(OP_WRITE, 2'(b), BASE + 9'(c), 1'b1);
            end
        end
        now(bank_open, 32'h0);
        for (int bi = 0; bi < 5; bi++) begin
            for (int iv = 0; iv < 2; iv++) begin
                for (int cv = 2; cv < 4; cv++) begin
                    blv = (bi == 4) ? BL_FULL : 3'(bi);
                    if (blv == BL_FULL && iv == 1) continue;
                    ilv = iv[0];
                    bk = 2'($random(seed));
                    s = BASE + ((blv == BL_FULL) ? 9'h000 : 9'($random(seed) & 7));
                    wr(REG_MODE, {25'h0, 3'(cv), ilv, blv});
                    op(OP_MODE, 2'h0, 9'h000, 1'b0);
                    op(OP_READ, bk, s, 1'b1);
                    n = (blv == BL_FULL) ? 8 : 1 << blv;
                    for (int j = 0; j < n; j++) begin
                        chk(REG_RDATA, {15'h0, 1'b1, mem[bk][3'(col_of(s, j, blv, ilv))]}, 32'h1FFFF);
                    end
                end
            end
        end
        wr(REG_MODE, 32'h233);
        chk(REG_MODE, 32'h233, 32'hFFF);
        op(OP_MODE, 2'h0, 9'h000, 1'b0);
        d = 16'($random(seed));
        wr(REG_WDATA, {14'h0, 2'h1, d});
        op(OP_WRITE, 2'h1, BASE, 1'b1);
        mem[1][0][15:8] = d[15:8];
        op(OP_READ, 2'h1, BASE, 1'b1);
        op(OP_READ, 2'h1, BASE, 1'b1);
        chk(REG_STATUS, 32'h200, 32'h3E0);
        for (int j = 0; j < 16; j++) begin
            chk(REG_RDATA, {15'h0, 1'b1, mem[1][j % 8]}, 32'h1FFFF);
        end
        chk(REG_RDATA, 32'h0, 32'h10000);
        op(OP_REFRESH, 2'h0, 9'h000, 1'b0);
        op(OP_PRE_ALL, 2'h0, 9'h000, 1'b0);
        now(bank_open, 32'h0);
        repeat (5) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule : tb_four_bank_sdram_burst_access
`default_nettype wire
